// ---- design/aux_seq_defs.svh ----
// Notes on behaviour
// RL1 - Balance taps 1..16 and the busbar share one round-robin slot and one multiplexer.
// RL2 - Settling select picks 4.3ms (default), 2.3ms or 1.3ms.
// RL3 - A tap or busbar sample is taken only after the settling time.
// RL4 - The shared slot converts only active and selected channels; others are skipped.
// RL5 - Active cell count is the highest active tap; taps above it are skipped.
// RL6 - Tap select: loop over active taps and busbar, lock one tap, or lock busbar.
// RL7 - Tap result updates only when locked to a valid channel; else it holds 0x8000.
// RL8 - Host should reset the converter whenever it locks a new tap.
// RL9 - Host runs a full continuous sweep before diagnostics or locking.
// RL10 - No post-conversion filter; raw tap results go to the internal comparison.
// RL11 - Every die sensor reading feeds gain and offset correction.
// RL12 - Die temperature is signed, zero at 0x00, clamped to +200 and -100 degrees.
// RL13 - One GPIO per round-robin cycle; a full sweep takes eight cycles.
// RL14 - Host enables thermistor bias and waits for it before starting.
// RL15 - GPIO result is written only when one GPIO is locked; else 0x8000.
// RL16 - All twelve miscellaneous inputs are measured in every round-robin cycle.
// RL17 - Protector threshold inputs are converted live, never latched.
// RL18 - A go write samples all configuration and the run starts from it.
// RL19 - Configuration changes act only after a further go write.
// RL20 - A running flag shows whether the converter sequence runs.
// RL21 - Misc-ready after all misc inputs measured; tap-ready after selected taps measured.
// RL22 - GPIO-ready after all GPIOs measured once; inactive GPIO results are dropped.
// RL23 - Modes: 00 stop, 01 one cycle, 10 continuous, 11 eight cycles.
// RL24 - The round robin holds 24 slots converted in turn.
// RL25 - Starting a run resets every result register to 0x8000.
// RL26 - After a high byte read, the low byte is frozen until it is read.
`ifndef AUX_SEQ_DEFS_SVH
`define AUX_SEQ_DEFS_SVH
`define REG_CTRL3      8'h00
`define REG_CTRL2      8'h01
`define REG_CONF1      8'h02
`define REG_CELLS      8'h03
`define REG_GPIO_ACT   8'h04
`define REG_STATUS     8'h05
`define RES_BASE       8'h10
`define RES_LAST       8'h2D
`define GO_BIT         6
`define GSEL_LSB       2
`define RES_DEFAULT    16'h8000
`define SLOT_DIE       5'h00
`define SLOT_TAP       5'h01
`define SLOT_GPIO      5'h02
`define SLOT_MISC_LAST 5'h0E
`define SLOT_LAST      5'h17
`define TAP_LOOP       5'h00
`define TAP_BUSBAR     5'h11
`define TAP_MAX        5'h10
`define RR_EIGHT_LAST  4'h7
`define CLK_PERIOD_NS  5
`define SETTLE_LONG_NS 4300000
`define SETTLE_MID_NS  2300000
`define SETTLE_SHORT_NS 1300000
`define DIE_MAX_CODE   16'h0C80
`define DIE_MIN_CODE   16'hF9C0
`endif

// ---- design/aux_seq_pkg.sv ----
package aux_seq_pkg;
  typedef enum logic [1:0] {
    MODE_STOP = 2'h0, MODE_SINGLE = 2'h1, MODE_CONT = 2'h2, MODE_EIGHT = 2'h3
  } run_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_START = 2'h1, ST_WAIT = 2'h3
  } state_e;
  typedef enum logic [2:0] {
    K_DIE = 3'h0, K_TAP = 3'h1, K_GPIO = 3'h2, K_MISC = 3'h3, K_SPARE = 3'h4
  } slot_kind_e;
  typedef struct packed {
    run_mode_e  mode;
    logic [4:0] tap_sel;
    logic [1:0] settle;
    logic [3:0] gpio_sel;
    logic [3:0] cells;
    logic [7:0] gpio_act;
  } cfg_s;
  typedef struct packed {
    slot_kind_e kind;
    logic [4:0] slot;
    logic [4:0] ch;
  } conv_req_s;
endpackage : aux_seq_pkg

// ---- design/redundant_adc_slot_sequencer.sv ----
`timescale 1ns/1ps
`include "aux_seq_defs.svh"
module redundant_adc_slot_sequencer #(
  parameter int unsigned NUM_RES      = 15,
  parameter logic [19:0] SETTLE_LONG  = 20'((`SETTLE_LONG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
  parameter logic [19:0] SETTLE_MID   = 20'((`SETTLE_MID_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS),
  parameter logic [19:0] SETTLE_SHORT = 20'((`SETTLE_SHORT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
) (
  // Clock and reset.
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  // Register port.
  input  wire logic [7:0]              reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // Converter request and answer.
  output logic                         conv_start,
  output aux_seq_pkg::conv_req_s       conv_req,
  input  wire logic                    conv_done,
  input  wire logic [15:0]             conv_data,
  // Shared tap multiplexer and internal users.
  output logic      [4:0]              tap_mux_sel,
  output logic      [15:0]             die_corr,
  output logic                         cmp_valid,
  output logic      [4:0]              cmp_tap,
  output logic      [15:0]             cmp_data
);

  aux_seq_pkg::cfg_s       cfg_q;
  aux_seq_pkg::cfg_s       act_q;
  aux_seq_pkg::cfg_s       act_d;
  aux_seq_pkg::state_e     st_q;
  aux_seq_pkg::slot_kind_e kind;
  logic [4:0]              slot_q;
  logic [4:0]              tap_ch_q;
  logic [4:0]              tap_next;
  logic [4:0]              tap_top;
  logic [19:0]             settle_q;
  logic [19:0]             settle_len;
  logic [2:0]              gpio_idx_q;
  logic [3:0]              rr_cnt_q;
  logic                    run_q;
  logic                    misc_rdy_q;
  logic                    tap_rdy_q;
  logic                    gpio_rdy_q;
  logic [7:0]              hi_q [NUM_RES];
  logic [7:0]              lo_q [NUM_RES];
  logic [NUM_RES-1:0]      hold_q;
  logic [NUM_RES-1:0]      res_we;
  logic [15:0]             res_wd;
  logic [15:0]             die_clamped;
  logic                    go;
  logic                    go_run;
  logic                    tap_locked;
  logic                    lock_ok;
  logic                    tap_do;
  logic                    gpio_lock_ok;
  logic                    done_now;
  logic                    rr_end;
  logic                    stop_now;
  logic [7:0]              roff;
  logic [3:0]              ridx;
  logic                    rd_res;
  logic [7:0]              rd_mux;
  logic                    do_store;

  assign go     = reg_wr && (reg_addr == `REG_CTRL3) && reg_wdata[`GO_BIT];
  assign go_run = go && (reg_wdata[1:0] != aux_seq_pkg::MODE_STOP);

  // The mode and GPIO lock travel in the go write itself; other fields come from the shadows.
  always_comb begin
    act_d          = cfg_q;
    act_d.mode     = aux_seq_pkg::run_mode_e'(reg_wdata[1:0]);
    act_d.gpio_sel = reg_wdata[`GSEL_LSB +: 4];
  end

  // Software shadows; they only steer the sequence once a go arrives.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL3) begin
        cfg_q.mode     <= aux_seq_pkg::run_mode_e'(reg_wdata[1:0]);
        cfg_q.gpio_sel <= reg_wdata[`GSEL_LSB +: 4];
      end else if (reg_addr == `REG_CTRL2) begin
        cfg_q.tap_sel <= reg_wdata[4:0];
      end else if (reg_addr == `REG_CONF1) begin
        cfg_q.settle <= reg_wdata[1:0];
      end else if (reg_addr == `REG_CELLS) begin
        cfg_q.cells <= reg_wdata[3:0];
      end else if (reg_addr == `REG_GPIO_ACT) begin
        cfg_q.gpio_act <= reg_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q <= '0;
    end else if (go) begin
      act_q <= act_d; // see RL18 see RL19
    end
  end

  // A cell count of zero is taken as a full sixteen-tap stack.
  assign tap_top    = (act_q.cells == 4'h0) ? `TAP_MAX : {1'b0, act_q.cells};
  assign tap_locked = act_q.tap_sel != `TAP_LOOP;
  assign lock_ok    = (act_q.tap_sel == `TAP_BUSBAR) ||
                      ((act_q.tap_sel != `TAP_LOOP) && (act_q.tap_sel <= tap_top)); // see RL5
  assign tap_do     = (kind == aux_seq_pkg::K_TAP) && (settle_q == 20'h0) &&
                      (!tap_locked || lock_ok); // see RL3 see RL4
  assign gpio_lock_ok = (act_q.gpio_sel != 4'h0) && (act_q.gpio_sel <= 4'h8) &&
                        act_q.gpio_act[3'(act_q.gpio_sel - 4'h1)]; // see RL22

  always_comb begin
    if (tap_ch_q == `TAP_BUSBAR) begin
      tap_next = 5'h01;
    end else if (tap_ch_q >= tap_top) begin
      tap_next = `TAP_BUSBAR;
    end else begin
      tap_next = tap_ch_q + 5'h01;
    end
  end

  always_comb begin
    if (act_q.settle == 2'h1) begin
      settle_len = SETTLE_MID; // see RL2
    end else if (act_q.settle == 2'h2) begin
      settle_len = SETTLE_SHORT;
    end else begin
      settle_len = SETTLE_LONG;
    end
  end

  // Slot map: die sensor, shared tap slot, GPIO slot, twelve misc, nine spares.
  always_comb begin
    if (slot_q == `SLOT_DIE) begin
      kind = aux_seq_pkg::K_DIE;
    end else if (slot_q == `SLOT_TAP) begin
      kind = aux_seq_pkg::K_TAP; // see RL1
    end else if (slot_q == `SLOT_GPIO) begin
      kind = aux_seq_pkg::K_GPIO;
    end else if (slot_q <= `SLOT_MISC_LAST) begin
      kind = aux_seq_pkg::K_MISC;
    end else begin
      kind = aux_seq_pkg::K_SPARE;
    end
  end

  assign done_now = (st_q == aux_seq_pkg::ST_WAIT) && conv_done;
  assign rr_end   = (slot_q == `SLOT_LAST) && done_now;
  assign stop_now = rr_end && ((act_q.mode == aux_seq_pkg::MODE_SINGLE) ||
                    ((act_q.mode == aux_seq_pkg::MODE_EIGHT) && (rr_cnt_q == `RR_EIGHT_LAST))); // see RL23

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= aux_seq_pkg::ST_IDLE;
      slot_q     <= 5'h00;
      run_q      <= 1'b0;
      conv_start <= 1'b0;
      conv_req   <= '0;
    end else begin
      conv_start <= 1'b0;
      if (go) begin
        st_q   <= go_run ? aux_seq_pkg::ST_START : aux_seq_pkg::ST_IDLE;
        run_q  <= go_run; // see RL20 see RL23
        slot_q <= `SLOT_DIE;
      end else begin
        case (st_q)
          aux_seq_pkg::ST_START: begin
            if ((kind == aux_seq_pkg::K_TAP) && !tap_do) begin
              slot_q <= slot_q + 5'h01; // see RL4
            end else begin
              conv_start    <= 1'b1;
              conv_req.kind <= kind;
              conv_req.slot <= slot_q;
              if (kind == aux_seq_pkg::K_TAP) begin
                conv_req.ch <= tap_ch_q;
              end else if (kind == aux_seq_pkg::K_GPIO) begin
                conv_req.ch <= gpio_lock_ok ? {1'b0, act_q.gpio_sel - 4'h1} : {2'h0, gpio_idx_q}; // see RL13
              end else begin
                conv_req.ch <= slot_q;
              end
              st_q <= aux_seq_pkg::ST_WAIT;
            end
          end
          aux_seq_pkg::ST_WAIT: begin
            if (conv_done) begin
              if (slot_q == `SLOT_LAST) begin
                slot_q <= `SLOT_DIE; // see RL24
                st_q   <= stop_now ? aux_seq_pkg::ST_IDLE : aux_seq_pkg::ST_START;
                run_q  <= !stop_now;
              end else begin
                slot_q <= slot_q + 5'h01;
                st_q   <= aux_seq_pkg::ST_START;
              end
            end
          end
          default: begin
            st_q <= aux_seq_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rr_cnt_q   <= 4'h0;
      gpio_idx_q <= 3'h0;
    end else if (go) begin
      rr_cnt_q   <= 4'h0;
      gpio_idx_q <= 3'h0;
    end else if (rr_end) begin
      rr_cnt_q   <= rr_cnt_q + 4'h1;
      gpio_idx_q <= gpio_idx_q + 3'h1; // see RL13
    end
  end

  // The settling wait restarts on every move of the shared multiplexer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_ch_q <= 5'h01;
      settle_q <= 20'h0;
    end else if (go_run) begin
      tap_ch_q <= (act_d.tap_sel == `TAP_LOOP) ? 5'h01 : act_d.tap_sel; // see RL6
      settle_q <= SETTLE_LONG;
      if (act_d.settle == 2'h1) begin
        settle_q <= SETTLE_MID;
      end else if (act_d.settle == 2'h2) begin
        settle_q <= SETTLE_SHORT;
      end
    end else if (done_now && (kind == aux_seq_pkg::K_TAP) && !tap_locked) begin
      tap_ch_q <= tap_next; // see RL6
      settle_q <= settle_len;
    end else if (run_q && (settle_q != 20'h0)) begin
      settle_q <= settle_q - 20'h1; // see RL3
    end
  end

  assign tap_mux_sel = tap_ch_q;

  always_comb begin
    if ($signed(conv_data) > $signed(`DIE_MAX_CODE)) begin
      die_clamped = `DIE_MAX_CODE; // see RL12
    end else if ($signed(conv_data) < $signed(`DIE_MIN_CODE)) begin
      die_clamped = `DIE_MIN_CODE;
    end else begin
      die_clamped = conv_data;
    end
  end

  // Results go straight from the converter, the die result only through its clamp; there is no smoothing stage.
  always_comb begin
    do_store = 1'b0;
    res_wd   = conv_data; // see RL10 see RL17
    res_we   = '0;
    if (done_now) begin
      case (kind)
        aux_seq_pkg::K_DIE: begin
          do_store = 1'b1;
          res_wd   = die_clamped;
        end
        aux_seq_pkg::K_TAP: begin
          do_store = tap_locked && lock_ok; // see RL7
        end
        aux_seq_pkg::K_GPIO: begin
          do_store = gpio_lock_ok; // see RL15
        end
        aux_seq_pkg::K_MISC: begin
          do_store = 1'b1; // see RL16
        end
        default: begin
          do_store = 1'b0;
        end
      endcase
      res_we[slot_q[3:0]] = do_store;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_RES; i++) begin
        hi_q[i] <= 8'h80;
        lo_q[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (go_run) begin
          hi_q[i] <= 8'(`RES_DEFAULT >> 8); // see RL25
          lo_q[i] <= 8'h00;
        end else if (res_we[i]) begin
          hi_q[i] <= res_wd[15:8];
          if (!hold_q[i]) begin
            lo_q[i] <= res_wd[7:0]; // see RL26
          end
        end
      end
    end
  end

  assign roff   = reg_addr - `RES_BASE;
  assign ridx   = roff[4:1];
  assign rd_res = (reg_addr >= `RES_BASE) && (reg_addr <= `RES_LAST);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (go_run) begin
      hold_q <= '0;
    end else if (reg_rd && rd_res) begin
      hold_q[ridx] <= !roff[0]; // see RL26
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      misc_rdy_q <= 1'b0;
      tap_rdy_q  <= 1'b0;
      gpio_rdy_q <= 1'b0;
    end else if (go_run) begin
      misc_rdy_q <= 1'b0;
      tap_rdy_q  <= 1'b0;
      gpio_rdy_q <= 1'b0;
    end else begin
      if (rr_end) begin
        misc_rdy_q <= 1'b1; // see RL21
      end
      if (rr_end && (gpio_idx_q == 3'h7)) begin
        gpio_rdy_q <= 1'b1; // see RL22
      end
      if (done_now && (kind == aux_seq_pkg::K_TAP) &&
          (tap_locked || (tap_ch_q == `TAP_BUSBAR))) begin
        tap_rdy_q <= 1'b1; // see RL21
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      die_corr  <= 16'h0000;
      cmp_valid <= 1'b0;
      cmp_tap   <= 5'h00;
      cmp_data  <= 16'h0000;
    end else begin
      cmp_valid <= 1'b0;
      if (res_we[0]) begin
        die_corr <= res_wd; // see RL11
      end
      if (done_now && (kind == aux_seq_pkg::K_TAP) && (tap_ch_q != `TAP_BUSBAR)) begin
        cmp_valid <= 1'b1; // see RL10
        cmp_tap   <= tap_ch_q;
        cmp_data  <= conv_data;
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (reg_addr == `REG_CTRL3) begin
      rd_mux = {2'h0, cfg_q.gpio_sel, cfg_q.mode};
    end else if (reg_addr == `REG_CTRL2) begin
      rd_mux = {3'h0, cfg_q.tap_sel};
    end else if (reg_addr == `REG_CONF1) begin
      rd_mux = {6'h00, cfg_q.settle};
    end else if (reg_addr == `REG_CELLS) begin
      rd_mux = {4'h0, cfg_q.cells};
    end else if (reg_addr == `REG_GPIO_ACT) begin
      rd_mux = cfg_q.gpio_act;
    end else if (reg_addr == `REG_STATUS) begin
      rd_mux = {4'h0, gpio_rdy_q, tap_rdy_q, misc_rdy_q, run_q};
    end else if (rd_res) begin
      rd_mux = roff[0] ? lo_q[ridx] : hi_q[ridx];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  sequence s_go_run;
    reg_wr && (reg_addr == `REG_CTRL3) && reg_wdata[`GO_BIT] && (reg_wdata[1:0] != 2'h0);
  endsequence

  property p_go_start;
    @(posedge sys_clk) disable iff (!rst_n) s_go_run |=> run_q && (slot_q == 5'h00);
  endproperty
  a_go_start: assert property (p_go_start) else $error("go did not start the run"); // see RL18

  property p_go_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      (go && (reg_wdata[1:0] == 2'h0)) |=> !run_q && !conv_start;
  endproperty
  a_go_stop: assert property (p_go_stop) else $error("stop go left the run on"); // see RL23

  property p_clear;
    @(posedge sys_clk) disable iff (!rst_n) s_go_run |=> (hi_q[1] == 8'h80) && (lo_q[2] == 8'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("results not cleared at start"); // see RL25

  property p_tap_loop_default;
    @(posedge sys_clk) disable iff (!rst_n)
      (run_q && !tap_locked) |=> $stable(hi_q[1]) && $stable(lo_q[1]);
  endproperty
  a_tap_loop_default: assert property (p_tap_loop_default) else $error("tap result moved in loop"); // see RL7

  property p_gpio_default;
    @(posedge sys_clk) disable iff (!rst_n) (run_q && !gpio_lock_ok && !go) |=> $stable(hi_q[2]);
  endproperty
  a_gpio_default: assert property (p_gpio_default) else $error("gpio result written unlocked"); // see RL15

  property p_tap_settled;
    @(posedge sys_clk) disable iff (!rst_n)
      (conv_start && (conv_req.kind == aux_seq_pkg::K_TAP)) |-> $past(settle_q) == 20'h0;
  endproperty
  a_tap_settled: assert property (p_tap_settled) else $error("tap converted before settling"); // see RL3

  property p_single_stop;
    @(posedge sys_clk) disable iff (!rst_n)
      (rr_end && (act_q.mode == aux_seq_pkg::MODE_SINGLE) && !go) |=> !run_q ##1 !conv_start;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single mode kept running"); // see RL23

  property p_lo_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (hold_q[0] && !go_run && !(reg_rd && rd_res && (ridx == 4'h0))) |=> $stable(lo_q[0]);
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("low byte refreshed while held"); // see RL26

  property p_die_clamp;
    @(posedge sys_clk) disable iff (!rst_n)
      (res_we[0] && !go_run) |=> ($signed(hi_q[0]) <= $signed(8'(`DIE_MAX_CODE >> 8))) &&
                                 ($signed(hi_q[0]) >= $signed(8'(`DIE_MIN_CODE >> 8)));
  endproperty
  a_die_clamp: assert property (p_die_clamp) else $error("die reading above clamp"); // see RL12

  property p_misc_ready;
    @(posedge sys_clk) disable iff (!rst_n) (rr_end && !go) |=> misc_rdy_q ##1 (misc_rdy_q || $past(go_run));
  endproperty
  a_misc_ready: assert property (p_misc_ready) else $error("misc ready not set"); // see RL21

endmodule : redundant_adc_slot_sequencer

// ---- verification/adc_answer_model.sv ----
`timescale 1ns/1ps
module adc_answer_model (
  // Clock and reset.
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // Request from the sequencer, and the die value to answer with.
  input  wire logic                  conv_start,
  input  wire aux_seq_pkg::conv_req_s conv_req,
  input  wire logic [15:0]           die_value,
  // Answer to the sequencer.
  output logic                       conv_done,
  output logic      [15:0]           conv_data
);
  logic [2:0] wait_q;

  // Odd slots answer at once and even slots late, so both latencies are exercised.
  // Outside an answer the data toggles, so a stale sample never looks valid.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q    <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= 16'h5A5A;
    end else begin
      conv_done <= (wait_q == 3'h1);
      if (conv_start)
        wait_q <= conv_req.slot[0] ? 3'h1 : 3'h4;
      else if (wait_q != 3'h0)
        wait_q <= wait_q - 3'h1;
      if (wait_q == 3'h1)
        conv_data <= (conv_req.kind == aux_seq_pkg::K_DIE) ? die_value
                     : {conv_req.kind, 3'h0, conv_req.slot, conv_req.ch};
      else
        conv_data <= ~conv_data;
    end
  end
endmodule : adc_answer_model

// ---- verification/test_redundant_adc_slot_sequencer.sv ----
`timescale 1ns/1ps
module test_redundant_adc_slot_sequencer;
  logic                   sys_clk;
  logic                   rst_n;
  logic [7:0]             reg_addr;
  logic [7:0]             reg_wdata;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [7:0]             reg_rdata;
  logic                   conv_start;
  aux_seq_pkg::conv_req_s conv_req;
  logic                   conv_done;
  logic [15:0]            conv_data;
  logic [4:0]             tap_mux_sel;
  logic [15:0]            die_corr;
  logic                   cmp_valid;
  logic [4:0]             cmp_tap;
  logic [15:0]            cmp_data;
  logic [15:0]            die_value;
  logic [7:0]             b;
  logic [7:0]             gpio_seen = 8'h00;
  int                     cnt [5] = '{default: 0};
  int                     base [5];
  int                     n_cmp = 0;
  int                     cmp_base;
  int                     fail_count;
  int                     n_checks;

  redundant_adc_slot_sequencer #(
    .SETTLE_LONG (20'h00014),
    .SETTLE_MID  (20'h0000A),
    .SETTLE_SHORT(20'h00005)
  ) redundant_adc_slot_sequencer_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
    .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
    .tap_mux_sel(tap_mux_sel), .die_corr(die_corr), .cmp_valid(cmp_valid),
    .cmp_tap(cmp_tap), .cmp_data(cmp_data)
  );

  adc_answer_model adc_answer_model_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .conv_start(conv_start), .conv_req(conv_req),
    .die_value(die_value), .conv_done(conv_done), .conv_data(conv_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (cmp_valid === 1'b1)
      n_cmp++;
    if (conv_start === 1'b1) begin
      cnt[int'(conv_req.kind)]++;
      if (conv_req.kind == aux_seq_pkg::K_GPIO)
        gpio_seen[conv_req.ch[2:0]] <= 1'b1;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // Reads the high byte first, as software must, so the low byte pairs with it.
  task automatic chk_res(input string name, input logic [7:0] a, input logic [15:0] exp);
    logic [7:0] h;
    logic [7:0] l;
    rd(a, h);
    rd(a + 8'h01, l);
    chk(name, {h, l}, exp);
  endtask : chk_res

  task automatic wait_status(input logic [7:0] mask, input logic [7:0] want);
    logic [7:0] s;
    for (int i = 0; i < 1000; i++) begin
      rd(8'h05, s);
      if ((s & mask) === want)
        return;
    end
    fail_count++;
    complete_run();
  endtask : wait_status

  task automatic wait_die(input logic [15:0] want);
    for (int i = 0; i < 600; i++) begin
      @(posedge sys_clk);
      if (die_corr === want)
        return;
    end
    fail_count++;
    complete_run();
  endtask : wait_die

  initial begin
    rst_n      = 1'b0;
    reg_addr   = 8'h00;
    reg_wdata  = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    die_value  = 16'h7000;
    fail_count = 0;
    n_checks   = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h05, b);
    chk("idle status", {8'h00, b}, 16'h0000);
    rd(8'h40, b);
    chk("unmapped", {8'h00, b}, 16'h0000);
    chk_res("die idle", 8'h10, 16'h8000);
    // A continuous run, waited on only until misc ready and the die checks, comes before any lock is attempted.
    // Thermistor bias is taken as enabled and settled before this first go.
    wr(8'h04, 8'hFF);
    wr(8'h02, 8'h02);
    wr(8'h03, 8'h0E);
    wr(8'h00, 8'h42);
    wait_status(8'h03, 8'h03);
    wait_die(16'h0C80);
    chk_res("die clamp high", 8'h10, 16'h0C80);
    rd(8'h10, b);
    die_value <= 16'h0123;
    wait_die(16'h0123);
    rd(8'h10, b);
    chk("die high fresh", {8'h00, b}, 16'h0001);
    rd(8'h11, b);
    chk("die low held", {8'h00, b}, 16'h0080);
    die_value <= 16'h8100;
    wait_die(16'hF9C0);
    chk_res("die clamp low", 8'h10, 16'hF9C0);
    chk_res("tap loop", 8'h12, 16'h8000);
    chk_res("gpio loop", 8'h14, 16'h8000);
    chk_res("misc slot", 8'h16, 16'h6063);
    wr(8'h00, 8'h40);
    wait_status(8'h01, 8'h00);
    // Lock tap 5 and GPIO3; stopping first restarts the converter.
    cmp_base = n_cmp;
    wr(8'h01, 8'h05);
    wr(8'h00, 8'h4E);
    wait_status(8'h04, 8'h04);
    chk("mux lock", {11'h000, tap_mux_sel}, 16'h0005);
    chk_res("tap lock", 8'h12, 16'h2025);
    chk("cmp tap", {11'h000, cmp_tap}, 16'h0005);
    chk("cmp data", cmp_data, 16'h2025);
    chk("cmp pulse", {15'h0000, n_cmp > cmp_base}, 16'h0001);
    wr(8'h01, 8'h06);
    wait_status(8'h08, 8'h08);
    chk("mux kept", {11'h000, tap_mux_sel}, 16'h0005);
    chk_res("gpio lock", 8'h14, 16'h4042);
    wr(8'h00, 8'h40);
    wait_status(8'h01, 8'h00);
    // Eight round robins with tap 15 locked while only 14 cells are active.
    base = cnt;
    cmp_base = n_cmp;
    gpio_seen = 8'h00;
    wr(8'h01, 8'h0F);
    wr(8'h00, 8'h43);
    wait_status(8'h01, 8'h00);
    chk("die count", 16'(cnt[0] - base[0]), 16'h0008);
    chk("tap count", 16'(cnt[1] - base[1]), 16'h0000);
    chk("gpio count", 16'(cnt[2] - base[2]), 16'h0008);
    chk("misc count", 16'(cnt[3] - base[3]), 16'h0060);
    chk("spare count", 16'(cnt[4] - base[4]), 16'h0048);
    chk("cmp none", 16'(n_cmp - cmp_base), 16'h0000);
    chk("gpio sweep", {8'h00, gpio_seen}, 16'h00FF);
    rd(8'h05, b);
    chk("ready flags", {8'h00, b & 8'h0A}, 16'h000A);
    chk_res("tap inactive", 8'h12, 16'h8000);
    base = cnt;
    wr(8'h00, 8'h41);
    wait_status(8'h01, 8'h00);
    chk("single die", 16'(cnt[0] - base[0]), 16'h0001);
    chk("single misc", 16'(cnt[3] - base[3]), 16'h000C);
    complete_run();
  end
endmodule : test_redundant_adc_slot_sequencer
